// file: shared/pmw_pkg.sv
// constants, types and the list of behaviours for the power mode and wake block
//
// Contract
// - seven sources, fixed vectors, fixed tie order
// - four priority levels, order breaks ties
// - halt bit write enters idle
// - idle freezes pc, clocks keep running
// - idle interrupt clears halt, resumes
// - reset ends any mode like power-on
// - power-down bit write enters power-down
// - power-down stops clocks, keeps state
// - only enabled external levels wake power-down
// - pin low restarts oscillator, 1024 cycles
// - service runs after wake pin rises
// - strobes high in idle, low in power-down
// - per-block clock gating by software
// - four slower system clock rates
// - divide 4/16/256/1024 when divider enabled
// - machine cycle 12 clocks, 6 doubled
// - doubling set by host/iap command only
// - doubling only internal clock and flash
package pmw_pkg;
   localparam int PMW_AW = 8;
   localparam int PMW_DW = 32;
   localparam int PMW_NSRC = 7;
   localparam logic [7:0] PMW_OFF_PCTRL = 8'h00;
   localparam logic [7:0] PMW_OFF_IRQEN = 8'h04;
   localparam logic [7:0] PMW_OFF_LVL = 8'h08;
   localparam logic [7:0] PMW_OFF_GATE = 8'h0C;
   localparam logic [7:0] PMW_OFF_DIV = 8'h10;
   localparam logic [7:0] PMW_OFF_FSTAT = 8'h14;
   localparam logic [7:0] PMW_OFF_STAT = 8'h18;
   localparam int PMW_BIT_HALT = 0;
   localparam int PMW_BIT_DOWN = 1;
   localparam int PMW_BIT_GLOBAL = 7;
   localparam int PMW_BIT_DIVEN = 4;
   localparam logic [2:0] PMW_SRC_EXT0 = 3'h0;
   localparam logic [2:0] PMW_SRC_EXT1 = 3'h3;
   localparam logic [7:0] PMW_RST_IRQEN = 8'h00;
   localparam logic [13:0] PMW_RST_LVL = 14'h0000;
   localparam logic [7:0] PMW_RST_GATE = 8'h00;
   localparam logic [1:0] PMW_RST_DIVSEL = 2'h0;
   localparam logic [2:0] PMW_RST_SYNC = 3'h7;
   localparam logic [10:0] PMW_WAKE_LOW_CYC = 11'h400;
   localparam logic [3:0] PMW_MC_STD = 4'hC;
   localparam logic [3:0] PMW_MC_DBL = 4'h6;
   localparam logic [6:0][15:0] PMW_VEC_TBL = {16'h002B, 16'h0023, 16'h001B, 16'h0013,
                                               16'h000B, 16'h0053, 16'h0003};
   localparam logic [3:0][9:0] PMW_DIV_LIM = {10'h3FF, 10'h0FF, 10'h00F, 10'h003};
   typedef enum logic [3:0] {
      PMW_ST_RUN = 4'b0001,
      PMW_ST_IDLE = 4'b0010,
      PMW_ST_PDOWN = 4'b0100,
      PMW_ST_WAKE = 4'b1000
   } pmw_state_t;
endpackage

// file: shared/pmw_core_if.sv
// signals between the controller, its arbiter and its clock divider
`timescale 1ns/1ns
`default_nettype none
interface pmw_core_if;
   logic [6:0] req;
   logic [13:0] lvl;
   logic valid;
   logic [2:0] idx;
   logic divEn;
   logic [1:0] divSel;
   logic run;
   logic tick;
   modport arb (input req, input lvl, output valid, output idx);
   modport div (input divEn, input divSel, input run, output tick);
   modport ctl (output req, output lvl, output divEn, output divSel, output run,
                input valid, input idx, input tick);
endinterface
`default_nettype wire

// file: hw/pmw_irq_arbiter.sv
// interrupt arbiter: highest level wins, lowest index breaks ties
`timescale 1ns/1ns
`default_nettype none
module pmw_irq_arbiter (
   pmw_core_if.arb bus
);
   import pmw_pkg::*;
   logic [PMW_NSRC-1:0][2:0] eff;
   genvar gi;
   generate
      for (gi = 0; gi < PMW_NSRC; gi = gi + 1) begin : g_src
         // bit 2 marks a live request above its level
         assign eff[gi] = bus.req[gi] ? {1'b1, bus.lvl[2*gi+1 -: 2]} : 3'h0;
      end
   endgenerate
   always_comb begin
      logic [2:0] best;
      logic [2:0] bidx;
      best = 3'h0;
      bidx = 3'h0;
      for (int i = 0; i < PMW_NSRC; i++) begin
         // strict compare keeps the earlier source on a tie
         if (eff[i] > best) begin
            best = eff[i];
            bidx = 3'(i);
         end
      end
      bus.valid = best[2];
      bus.idx = bidx;
   end
endmodule // pmw_irq_arbiter
`default_nettype wire

// file: hw/pmw_clk_div.sv
// system clock rate divider producing a tick enable
`timescale 1ns/1ns
`default_nettype none
module pmw_clk_div (
   input wire logic clk,
   input wire logic nrst,
   pmw_core_if.div bus
);
   import pmw_pkg::*;
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } pmw_div_t;
   pmw_div_t s;
   pmw_div_t n;
   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (!bus.run) begin
         n.cnt = 10'h000;
      end else if (!bus.divEn) begin
         n.tick = 1'b1;
         n.cnt = 10'h000;
      end else if (s.cnt >= PMW_DIV_LIM[bus.divSel]) begin
         n.tick = 1'b1;
         n.cnt = 10'h000;
      end else begin
         n.cnt = s.cnt + 10'h001;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
   assign bus.tick = s.tick;
endmodule // pmw_clk_div
`default_nettype wire

// file: hw/pmw_power_top.sv
// power mode controller: idle, power-down, wake, clock options and apb registers
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pmw_power_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmw_pkg::PMW_AW-1:0] paddr,
   input wire logic [pmw_pkg::PMW_DW-1:0] pwdata,
   output logic [pmw_pkg::PMW_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext0PinN,
   input wire logic ext1PinN,
   input wire logic externalAccessPin,
   input wire logic wdogIrq,
   input wire logic tmr0Flag,
   input wire logic tmr1Flag,
   input wire logic tmr2Flag,
   input wire logic tmr2CaptureFlag,
   input wire logic uartTxDoneFlag,
   input wire logic uartRxFullFlag,
   input wire logic instrDone,
   input wire logic irqReady,
   input wire logic hostDoubleCmd,
   input wire logic iapDoubleCmd,
   input wire logic coreAle,
   input wire logic coreStoreStrobe,
   output logic cpuRun,
   output logic oscRun,
   output logic sysTick,
   output logic machTick,
   output logic irqTake,
   output logic [15:0] irqVector,
   output logic addressLatchStrobe,
   output logic programStoreStrobe,
   output logic [7:0] blkClkEn,
   output logic flashFastEn
);
   import pmw_pkg::*;

   typedef struct packed {
      pmw_state_t st;
      logic haltBit;
      logic downBit;
      logic entryArm;
      logic [7:0] irqEn;
      logic [13:0] lvlSel;
      logic [7:0] clkGate;
      logic divEn;
      logic [1:0] divSel;
      logic sixClock;
      logic [31:0] rdData;
      logic [10:0] wakeCnt;
      logic [2:0] wakeIdx;
      logic [3:0] mcCnt;
      logic machTick;
      logic irqTake;
      logic [15:0] irqVector;
      logic [2:0] lastIdx;
      logic [2:0] ext0Sync;
      logic [2:0] ext1Sync;
      logic [2:0] accSync;
      logic ext0Flag;
      logic ext1Flag;
      logic accLvl;
   } pmw_main_t;

   pmw_main_t s;
   pmw_main_t n;
   pmw_core_if coreBus();
   logic [6:0] srcReq;
   logic [6:0] enReq;
   logic wake0;
   logic wake1;
   logic apbWr;
   logic addrHit;
   logic clocksOn;
   logic [3:0] mcLen;
   logic [31:0] rdMux;

   pmw_irq_arbiter u_arb (
      .bus(coreBus)
   );

   pmw_clk_div u_div (
      .clk(clk),
      .nrst(nrst),
      .bus(coreBus)
   );

   // source order fixes the tie order
   assign srcReq = {tmr2Flag | tmr2CaptureFlag, uartTxDoneFlag | uartRxFullFlag, tmr1Flag,
                    s.ext1Flag, tmr0Flag, wdogIrq, s.ext0Flag};
   assign enReq = srcReq & s.irqEn[6:0] & {7{s.irqEn[PMW_BIT_GLOBAL]}};
   assign wake0 = enReq[PMW_SRC_EXT0];
   assign wake1 = enReq[PMW_SRC_EXT1];
   assign clocksOn = (s.st == PMW_ST_RUN) || (s.st == PMW_ST_IDLE);
   // no source reaches the arbiter outside run and idle; wake0 and wake1 bypass it
   assign coreBus.req = clocksOn ? enReq : 7'h00;
   assign coreBus.lvl = s.lvlSel;
   assign coreBus.divEn = s.divEn;
   assign coreBus.divSel = s.divSel;
   assign coreBus.run = clocksOn;
   assign mcLen = s.sixClock ? PMW_MC_DBL : PMW_MC_STD;
   assign apbWr = psel && penable && pwrite;

   always_comb begin
      addrHit = 1'b1;
      rdMux = 32'h0000_0000;
      case (paddr)
         PMW_OFF_PCTRL: begin
            rdMux[PMW_BIT_HALT] = s.haltBit;
            rdMux[PMW_BIT_DOWN] = s.downBit;
         end
         PMW_OFF_IRQEN: rdMux[7:0] = s.irqEn;
         PMW_OFF_LVL: rdMux[13:0] = s.lvlSel;
         PMW_OFF_GATE: rdMux[7:0] = s.clkGate;
         PMW_OFF_DIV: begin
            rdMux[PMW_BIT_DIVEN] = s.divEn;
            rdMux[1:0] = s.divSel;
         end
         PMW_OFF_FSTAT: rdMux[0] = s.sixClock;
         PMW_OFF_STAT: rdMux[11:0] = {s.accLvl, s.lastIdx, s.entryArm, s.ext1Flag, s.ext0Flag,
                                      1'b0, s.st};
         default: addrHit = 1'b0;
      endcase
   end

   always_comb begin
      n = s;
      n.irqTake = 1'b0;
      n.machTick = 1'b0;
      // three-stage pin synchronisers, change taken when stages two and three agree
      n.ext0Sync = {s.ext0Sync[1:0], ext0PinN};
      n.ext1Sync = {s.ext1Sync[1:0], ext1PinN};
      n.accSync = {s.accSync[1:0], externalAccessPin};
      if (s.ext0Sync[1] == s.ext0Sync[2]) begin
         n.ext0Flag = ~s.ext0Sync[2];
      end
      if (s.ext1Sync[1] == s.ext1Sync[2]) begin
         n.ext1Flag = ~s.ext1Sync[2];
      end
      if (s.accSync[1] == s.accSync[2]) begin
         n.accLvl = s.accSync[2];
      end
      // doubling has no register write path, only the two commands
      if (hostDoubleCmd || iapDoubleCmd) begin
         n.sixClock = 1'b1;
      end
      if (coreBus.tick) begin
         if (s.mcCnt >= mcLen - 4'h1) begin
            n.mcCnt = 4'h0;
            n.machTick = 1'b1;
         end else begin
            n.mcCnt = s.mcCnt + 4'h1;
         end
      end
      case (s.st)
         PMW_ST_RUN: begin
            if (s.entryArm && instrDone) begin
               n.entryArm = 1'b0;
               if (s.downBit) begin
                  n.st = PMW_ST_PDOWN;
               end else if (s.haltBit) begin
                  n.st = PMW_ST_IDLE;
               end
            end else if (coreBus.valid && irqReady) begin
               n.irqTake = 1'b1;
               n.irqVector = PMW_VEC_TBL[coreBus.idx];
               n.lastIdx = coreBus.idx;
            end
         end
         PMW_ST_IDLE: begin
            if (coreBus.valid) begin
               n.irqTake = 1'b1;
               n.irqVector = PMW_VEC_TBL[coreBus.idx];
               n.lastIdx = coreBus.idx;
               n.haltBit = 1'b0;
               n.st = PMW_ST_RUN;
            end
         end
         PMW_ST_PDOWN: begin
            if (wake0 || wake1) begin
               n.st = PMW_ST_WAKE;
               n.wakeCnt = 11'h000;
               n.wakeIdx = wake0 ? PMW_SRC_EXT0 : PMW_SRC_EXT1;
            end
         end
         PMW_ST_WAKE: begin
            if (wake0 || wake1) begin
               if (s.wakeCnt != PMW_WAKE_LOW_CYC) begin
                  n.wakeCnt = s.wakeCnt + 11'h001;
               end
            end else if (s.wakeCnt == PMW_WAKE_LOW_CYC) begin
               n.st = PMW_ST_RUN;
               n.downBit = 1'b0;
               n.irqTake = 1'b1;
               n.irqVector = PMW_VEC_TBL[s.wakeIdx];
               n.lastIdx = s.wakeIdx;
            end else begin
               n.st = PMW_ST_PDOWN;
            end
         end
         default: n.st = PMW_ST_RUN;
      endcase
      // software write placed last so a set beats a same-cycle clear
      if (apbWr) begin
         case (paddr)
            PMW_OFF_PCTRL: begin
               n.haltBit = pwdata[PMW_BIT_HALT];
               n.downBit = pwdata[PMW_BIT_DOWN];
               n.entryArm = pwdata[PMW_BIT_HALT] | pwdata[PMW_BIT_DOWN];
            end
            PMW_OFF_IRQEN: n.irqEn = pwdata[7:0];
            PMW_OFF_LVL: n.lvlSel = pwdata[13:0];
            PMW_OFF_GATE: n.clkGate = pwdata[7:0];
            PMW_OFF_DIV: begin
               n.divEn = pwdata[PMW_BIT_DIVEN];
               n.divSel = pwdata[1:0];
            end
            default: begin end
         endcase
      end
      if (psel && !penable) begin
         n.rdData = rdMux;
      end
   end

   // synchronous reset ends any mode and restarts as at power-on
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
         s.st <= PMW_ST_RUN;
         s.irqEn <= PMW_RST_IRQEN;
         s.lvlSel <= PMW_RST_LVL;
         s.clkGate <= PMW_RST_GATE;
         s.divSel <= PMW_RST_DIVSEL;
         s.ext0Sync <= PMW_RST_SYNC;
         s.ext1Sync <= PMW_RST_SYNC;
         s.accSync <= PMW_RST_SYNC;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.rdData;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrHit;
   assign cpuRun = (s.st == PMW_ST_RUN);
   assign oscRun = (s.st != PMW_ST_PDOWN);
   assign sysTick = coreBus.tick;
   assign machTick = s.machTick;
   assign irqTake = s.irqTake;
   assign irqVector = s.irqVector;
   // doubling never reaches external fetches; oscillator pin stays undoubled
   assign flashFastEn = s.sixClock && s.accLvl;

   always_comb begin
      case (s.st)
         PMW_ST_IDLE: begin
            addressLatchStrobe = 1'b1;
            programStoreStrobe = 1'b1;
         end
         PMW_ST_PDOWN, PMW_ST_WAKE: begin
            addressLatchStrobe = 1'b0;
            programStoreStrobe = 1'b0;
         end
         default: begin
            addressLatchStrobe = coreAle;
            programStoreStrobe = coreStoreStrobe;
         end
      endcase
   end

   genvar gb;
   generate
      for (gb = 0; gb < 8; gb = gb + 1) begin : g_gate
         assign blkClkEn[gb] = clocksOn && !s.clkGate[gb];
      end
   endgenerate

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_idle_strobes;
      (s.st == PMW_ST_IDLE) |-> (addressLatchStrobe && programStoreStrobe);
   endproperty
   a_idle_strobes: assert property (p_idle_strobes) else $error("strobes not high in idle");

   property p_down_strobes;
      (s.st == PMW_ST_PDOWN) |-> (!addressLatchStrobe && !programStoreStrobe && !oscRun);
   endproperty
   a_down_strobes: assert property (p_down_strobes) else $error("power-down outputs wrong");

   property p_down_clocks;
      (s.st == PMW_ST_PDOWN) |-> (blkClkEn == 8'h00 && !cpuRun) ##1 !sysTick;
   endproperty
   a_down_clocks: assert property (p_down_clocks) else $error("clocks alive in power-down");

   property p_entry_after_instr;
      (s.st == PMW_ST_RUN && n.st != PMW_ST_RUN) |-> (instrDone && s.entryArm);
   endproperty
   a_entry_after_instr: assert property (p_entry_after_instr) else $error("mode entered early");

   property p_idle_exit;
      (s.st == PMW_ST_IDLE && coreBus.valid) |=> (irqTake && cpuRun && !s.haltBit);
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");

   property p_down_no_take;
      (s.st == PMW_ST_PDOWN) |=> !irqTake;
   endproperty
   a_down_no_take: assert property (p_down_no_take) else $error("interrupt taken in power-down");

   property p_wake_len;
      (s.st == PMW_ST_WAKE && n.st == PMW_ST_RUN) |-> (s.wakeCnt == PMW_WAKE_LOW_CYC);
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake before low time");

   property p_wake_vector;
      (s.st == PMW_ST_WAKE ##1 s.st == PMW_ST_RUN) |-> irqTake && !s.downBit &&
         (irqVector == PMW_VEC_TBL[PMW_SRC_EXT0] || irqVector == PMW_VEC_TBL[PMW_SRC_EXT1]);
   endproperty
   a_wake_vector: assert property (p_wake_vector) else $error("wake vector wrong");

   property p_mc_spacing;
      (machTick && !s.divEn) |=> !machTick [*5];
   endproperty
   a_mc_spacing: assert property (p_mc_spacing) else $error("machine cycle too short");

   property p_six_sticky;
      $past(s.sixClock) |-> s.sixClock;
   endproperty
   a_six_sticky: assert property (p_six_sticky) else $error("six clock flag lost");

   property p_take_enabled;
      irqTake |-> $past(s.irqEn[PMW_BIT_GLOBAL]);
   endproperty
   a_take_enabled: assert property (p_take_enabled) else $error("disabled source served");

   c_idle_round: cover property (s.st == PMW_ST_IDLE ##[1:50] irqTake);
   c_down_wake: cover property (s.st == PMW_ST_WAKE ##1 s.st == PMW_ST_RUN);
   c_down_abort: cover property (s.st == PMW_ST_WAKE ##1 s.st == PMW_ST_PDOWN);
   c_six_clock: cover property ($rose(s.sixClock));
endmodule // pmw_power_top
`default_nettype wire

// file: verif/pmw_host_model.sv
// model of the core, the wake pins and the doubling command source
`timescale 1ns/1ns
`default_nettype none
module pmw_host_model (
   input wire logic clk,
   output logic ext0PinN,
   output logic ext1PinN,
   output logic instrDone,
   output logic irqReady,
   output logic hostDoubleCmd,
   output logic iapDoubleCmd,
   output logic coreAle,
   output logic coreStoreStrobe
);
   initial begin
      ext0PinN = 1'b1;
      ext1PinN = 1'b1;
      instrDone = 1'b0;
      irqReady = 1'b1;
      hostDoubleCmd = 1'b0;
      iapDoubleCmd = 1'b0;
      coreAle = 1'b0;
      coreStoreStrobe = 1'b1;
   end
   // core strobes toggle so idle and power-down levels stand out
   always @(posedge clk) begin
      coreAle <= ~coreAle;
      coreStoreStrobe <= coreAle;
   end
   // one-cycle end of the current instruction
   task automatic pulse_done();
      instrDone <= 1'b1;
      @(posedge clk);
      instrDone <= 1'b0;
   endtask
   // pins rest high, low only while a wake is wanted
   task automatic set_pin(input int i, input logic lvl);
      if (i == 0) begin
         ext0PinN <= lvl;
      end else begin
         ext1PinN <= lvl;
      end
   endtask
   task automatic double_cmd(input logic iap);
      if (iap) begin
         iapDoubleCmd <= 1'b1;
      end else begin
         hostDoubleCmd <= 1'b1;
      end
      @(posedge clk);
      hostDoubleCmd <= 1'b0;
      iapDoubleCmd <= 1'b0;
   endtask
endmodule // pmw_host_model
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the power mode and wake block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pmw_pkg::*;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, ext0PinN, ext1PinN, externalAccessPin;
   logic [PMW_AW-1:0] paddr;
   logic [PMW_DW-1:0] pwdata, prdata, rd;
   logic wdogIrq, tmr0Flag, tmr1Flag, tmr2Flag, tmr2CaptureFlag, uartTxDoneFlag, uartRxFullFlag;
   logic instrDone, irqReady, hostDoubleCmd, iapDoubleCmd, coreAle, coreStoreStrobe, cpuRun, oscRun;
   logic sysTick, machTick, irqTake, addressLatchStrobe, programStoreStrobe, flashFastEn, err;
   logic [15:0] irqVector;
   logic [7:0] blkClkEn;
   int miscompares, samplesChecked, cs, cm;
   logic [15:0] vecExp [7] = '{16'h0003, 16'h0053, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
   int divs [4] = '{4, 16, 256, 1024};

   pmw_power_top pmw_power_top_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext0PinN(ext0PinN), .ext1PinN(ext1PinN), .externalAccessPin(externalAccessPin), .wdogIrq(wdogIrq),
      .tmr0Flag(tmr0Flag), .tmr1Flag(tmr1Flag), .tmr2Flag(tmr2Flag), .tmr2CaptureFlag(tmr2CaptureFlag),
      .uartTxDoneFlag(uartTxDoneFlag), .uartRxFullFlag(uartRxFullFlag), .instrDone(instrDone),
      .irqReady(irqReady), .hostDoubleCmd(hostDoubleCmd), .iapDoubleCmd(iapDoubleCmd), .coreAle(coreAle),
      .coreStoreStrobe(coreStoreStrobe), .cpuRun(cpuRun), .oscRun(oscRun), .sysTick(sysTick), .machTick(machTick),
      .irqTake(irqTake), .irqVector(irqVector), .addressLatchStrobe(addressLatchStrobe),
      .programStoreStrobe(programStoreStrobe), .blkClkEn(blkClkEn), .flashFastEn(flashFastEn));
   pmw_host_model pmw_host_model_i (.clk(clk), .ext0PinN(ext0PinN), .ext1PinN(ext1PinN),
      .instrDone(instrDone), .irqReady(irqReady), .hostDoubleCmd(hostDoubleCmd),
      .iapDoubleCmd(iapDoubleCmd), .coreAle(coreAle), .coreStoreStrobe(coreStoreStrobe));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   // apb transfer: setup, then access held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rd & m, exp, msg);
   endtask
   // raise or drop one source, called right after a clock edge
   task automatic req(input int i, input logic v);
      case (i)
         0: pmw_host_model_i.set_pin(0, !v);
         1: wdogIrq <= v;
         2: tmr0Flag <= v;
         3: pmw_host_model_i.set_pin(1, !v);
         4: tmr1Flag <= v;
         5: uartRxFullFlag <= v;
         default: tmr2Flag <= v;
      endcase
   endtask
   task automatic wait_take(input logic [15:0] exp, input string msg);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irqTake !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         miscompares++;
         give_verdict();
      end
      check(32'(irqVector), 32'(exp), msg);
   endtask
   task automatic count(input int n);
      cs = 0;
      cm = 0;
      repeat (n) begin
         @(posedge clk);
         cs += (sysTick === 1'b1);
         cm += (machTick === 1'b1);
      end
   endtask

   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {wdogIrq, tmr0Flag, tmr1Flag, tmr2Flag, tmr2CaptureFlag, uartTxDoneFlag, uartRxFullFlag} = '0;
      externalAccessPin = 1'b1;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rdm(PMW_OFF_IRQEN, 32'hFFFFFFFF, 32'h0, "irq enable reset");
      rdm(PMW_OFF_LVL, 32'hFFFFFFFF, 32'h0, "level reset");
      rdm(PMW_OFF_DIV, 32'hFFFFFFFF, 32'h0, "divider reset");
      rdm(PMW_OFF_STAT, 32'hF, 32'h1, "state reset");
      apb(1'b0, 8'h40, 32'h0);
      check(32'(err), 32'h1, "unmapped error");
      wr_vectors();
      // idle, entry only after the instruction ends
      apb(1'b1, PMW_OFF_PCTRL, 32'h1);
      repeat (4) @(posedge clk);
      check(32'(cpuRun), 32'h1, "early entry");
      pmw_host_model_i.pulse_done();
      repeat (2) @(posedge clk);
      check(32'(cpuRun), 32'h0, "idle pc");
      check(32'({addressLatchStrobe, programStoreStrobe}), 32'h3, "idle strobes");
      count(20);
      check(32'(cs), 32'd20, "idle clock");
      apb(1'b1, PMW_OFF_IRQEN, 32'hFB);
      req(2, 1'b1);
      repeat (20) @(posedge clk);
      rdm(PMW_OFF_STAT, 32'hF, 32'h2, "disabled wake");
      req(2, 1'b0);
      req(4, 1'b1);
      wait_take(16'h001B, "idle vector");
      req(4, 1'b0);
      repeat (2) @(posedge clk);
      check(32'(cpuRun), 32'h1, "idle exit");
      rdm(PMW_OFF_PCTRL, 32'h3, 32'h0, "halt cleared");
      // power-down, timer cannot wake, short pin pulse refused
      apb(1'b1, PMW_OFF_IRQEN, 32'hFF);
      apb(1'b1, PMW_OFF_PCTRL, 32'h2);
      pmw_host_model_i.pulse_done();
      repeat (2) @(posedge clk);
      check(32'({oscRun, blkClkEn}), 32'h0, "down clocks");
      check(32'({addressLatchStrobe, programStoreStrobe}), 32'h0, "down strobes");
      req(2, 1'b1);
      repeat (20) @(posedge clk);
      rdm(PMW_OFF_STAT, 32'hF, 32'h4, "timer wake");
      req(2, 1'b0);
      pmw_host_model_i.set_pin(0, 1'b0);
      repeat (100) @(posedge clk);
      pmw_host_model_i.set_pin(0, 1'b1);
      repeat (10) @(posedge clk);
      rdm(PMW_OFF_STAT, 32'hF, 32'h4, "short wake");
      pmw_host_model_i.set_pin(1, 1'b0);
      repeat (10) @(posedge clk);
      check(32'(oscRun), 32'h1, "osc restart");
      repeat (1030) @(posedge clk);
      pmw_host_model_i.set_pin(1, 1'b1);
      wait_take(16'h0013, "wake vector");
      repeat (2) @(posedge clk);
      check(32'(cpuRun), 32'h1, "down exit");
      rdm(PMW_OFF_PCTRL, 32'h3, 32'h0, "down cleared");
      rdm(PMW_OFF_IRQEN, 32'hFF, 32'hFF, "down retain");
      // reset in idle
      apb(1'b1, PMW_OFF_PCTRL, 32'h1);
      pmw_host_model_i.pulse_done();
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdm(PMW_OFF_STAT, 32'hF, 32'h1, "reset exit");
      rdm(PMW_OFF_PCTRL, 32'h3, 32'h0, "reset ctrl");
      apb(1'b1, PMW_OFF_GATE, 32'h5);
      @(posedge clk);
      check(32'(blkClkEn), 32'hFA, "gating");
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, PMW_OFF_DIV, 32'h10 | s);
         repeat (2 * divs[s]) @(posedge clk);
         count(4 * divs[s]);
         check(32'(cs), 32'd4, "divider rate");
      end
      apb(1'b1, PMW_OFF_DIV, 32'h0);
      repeat (30) @(posedge clk);
      count(24);
      check(32'(cm), 32'd2, "machine cycle");
      check(32'(flashFastEn), 32'h0, "no doubling");
      apb(1'b1, PMW_OFF_FSTAT, 32'h1);
      rdm(PMW_OFF_FSTAT, 32'h1, 32'h0, "six clock off");
      pmw_host_model_i.double_cmd(1'b0);
      repeat (30) @(posedge clk);
      rdm(PMW_OFF_FSTAT, 32'h1, 32'h1, "six clock on");
      count(24);
      check(32'(cm), 32'd4, "doubled cycle");
      check(32'(flashFastEn), 32'h1, "fast flash");
      externalAccessPin <= 1'b0;
      repeat (8) @(posedge clk);
      check(32'(flashFastEn), 32'h0, "external access");
      // second reset clears doubling, then the in-application command sets it
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdm(PMW_OFF_FSTAT, 32'h1, 32'h0, "reset six clock");
      pmw_host_model_i.double_cmd(1'b1);
      repeat (2) @(posedge clk);
      rdm(PMW_OFF_FSTAT, 32'h1, 32'h1, "iap double");
      give_verdict();
   end

   // every source alone, then tie order, then level
   task automatic wr_vectors();
      apb(1'b1, PMW_OFF_IRQEN, 32'hFF);
      for (int i = 0; i < 7; i++) begin
         req(i, 1'b1);
         wait_take(vecExp[i], "vector");
         req(i, 1'b0);
         repeat (12) @(posedge clk);
      end
      for (int j = 1; j < 7; j++) begin
         if (j != 3) begin
            req(j, 1'b1);
         end
      end
      wait_take(16'h0053, "tie order");
      for (int j = 1; j < 7; j++) begin
         req(j, 1'b0);
      end
      repeat (12) @(posedge clk);
      apb(1'b1, PMW_OFF_LVL, 32'h3000);
      req(2, 1'b1);
      req(6, 1'b1);
      wait_take(16'h002B, "level wins");
      req(2, 1'b0);
      req(6, 1'b0);
      repeat (12) @(posedge clk);
      apb(1'b1, PMW_OFF_LVL, 32'h0);
   endtask
endmodule // tb
`default_nettype wire
